// ===== common/frt_pkg.sv
/*
  Shared constants and types of the free-running timer: register map,
  field positions, reset values and clock-select codes.
  Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package frt_pkg;

  localparam int ADDR_W = 8;

  localparam logic [7:0] OFS_CTRL1   = 8'h00;
  localparam logic [7:0] OFS_CTRL2   = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_CNT_HI  = 8'h0C;
  localparam logic [7:0] OFS_CNT_LO  = 8'h10;
  localparam logic [7:0] OFS_ALT_HI  = 8'h14;
  localparam logic [7:0] OFS_ALT_LO  = 8'h18;
  localparam logic [7:0] OFS_CAP1_HI = 8'h1C;
  localparam logic [7:0] OFS_CAP1_LO = 8'h20;
  localparam logic [7:0] OFS_CAP2_HI = 8'h24;
  localparam logic [7:0] OFS_CAP2_LO = 8'h28;

  localparam logic [15:0] COUNT_RESET = 16'hFFFC;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;

  // clock select codes; external clock is fixed at both bits set
  localparam logic [1:0] SEL_DIV4 = 2'h0;
  localparam logic [1:0] SEL_DIV2 = 2'h1;
  localparam logic [1:0] SEL_DIV8 = 2'h2;
  localparam logic [1:0] SEL_EXT  = 2'h3;

  localparam logic [2:0] MASK_DIV2 = 3'h1;
  localparam logic [2:0] MASK_DIV4 = 3'h3;
  localparam logic [2:0] MASK_DIV8 = 3'h7;

  localparam int STAT_OVF     = 0;
  localparam int STAT_CAP_LSB = 1;
  localparam int STAT_PIN_LSB = 4;

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic capEdgeOne;
    logic capIrqEn;
    logic ovfIrqEn;
  } frt_ctrl1_t;

  typedef struct packed {
    logic       capEdgeTwo;
    logic       extEdge;
    logic [1:0] clockSel;
  } frt_ctrl2_t;

  localparam frt_ctrl1_t CTRL1_RESET = 3'h0;
  localparam frt_ctrl2_t CTRL2_RESET = 4'h0;

endpackage : frt_pkg

// ===== design/frt_pin_sync.sv
/*
  Two-stage synchroniser for the timer pins, plus one more stage that
  gives the previous synchronised level for edge detection.
  Assumes pins are asynchronous to ref_clk.
*/
`timescale 1ns/1ns
module frt_pin_sync
  import frt_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] pinIn,
  input  wire logic [WIDTH-1:0] pinReset,
  output logic      [WIDTH-1:0] levelNow,
  output logic      [WIDTH-1:0] levelPrev
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;

  always_comb begin
    meta_d = pinIn;
  end

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q    <= '1;
      levelNow  <= '1;
      levelPrev <= '1;
    end else begin
      meta_q    <= meta_d;
      levelNow  <= meta_q;
      levelPrev <= levelNow;
    end
  end

  // pinReset is only a documented idle level; kept equal to reset constant
  logic unusedIdle;
  assign unusedIdle = &pinReset;

endmodule : frt_pin_sync

// ===== design/frt_timer.sv
/*
  Free-running 16-bit timer with prescaler or external clock, buffered
  count views, overflow flag and two input-capture channels, behind an
  AHB-Lite slave. Assumes one 50 MHz clock, async active-low reset, the
  CPU interrupt mask and halt state as same-clock inputs.
*/
`timescale 1ns/1ns
module frt_timer
  import frt_pkg::*;
#(
  parameter bit EXT_BONDED  = 1'b1,
  parameter bit CAP1_BONDED = 1'b1,
  parameter bit CAP2_BONDED = 1'b1
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic        globalIrqMask,
  input  wire logic        haltMode,
  input  wire logic        extClockPin,
  input  wire logic        capturePinOne,
  input  wire logic        capturePinTwo,
  output logic             timerIrq
);

  function automatic logic [7:0] byteOf(input logic [15:0] v, input logic hi);
    byteOf = hi ? v[15:8] : v[7:0];
  endfunction : byteOf

  function automatic logic [2:0] prescMask(input logic [1:0] sel);
    case (sel)
      SEL_DIV2: prescMask = MASK_DIV2;
      SEL_DIV8: prescMask = MASK_DIV8;
      default:  prescMask = MASK_DIV4;
    endcase
  endfunction : prescMask

  function automatic logic edgeHit(input logic now, input logic prev, input logic rise);
    edgeHit = rise ? (now & ~prev) : (~now & prev);
  endfunction : edgeHit

  // pins; index 0 external clock, 1 and 2 the capture channels
  logic [2:0] pinRaw;
  logic [2:0] pinNow;
  logic [2:0] pinPrev;

  always_comb begin
    pinRaw[0] = EXT_BONDED  ? extClockPin   : 1'b1;
    pinRaw[1] = CAP1_BONDED ? capturePinOne : 1'b1;
    pinRaw[2] = CAP2_BONDED ? capturePinTwo : 1'b1;
  end

  frt_pin_sync #(
    .WIDTH (3)
  ) uPinSync (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .pinIn     (pinRaw),
    .pinReset  (3'h7),
    .levelNow  (pinNow),
    .levelPrev (pinPrev)
  );

  // state
  logic              dph_q,     dph_d;
  logic              dphWr_q,   dphWr_d;
  logic [7:0]        dphAddr_q, dphAddr_d;
  logic [31:0]       hrdata_q,  hrdata_d;
  frt_ctrl1_t        ctrl1_q,   ctrl1_d;
  frt_ctrl2_t        ctrl2_q,   ctrl2_d;
  logic [15:0]       count_q,   count_d;
  logic [2:0]        presc_q,   presc_d;
  logic              ovf_q,     ovf_d;
  logic              ovfArm_q,  ovfArm_d;
  logic [1:0]        capFlag_q, capFlag_d;
  logic [1:0]        capArm_q,  capArm_d;
  logic [1:0]        capLock_q, capLock_d;
  logic [1:0][15:0]  cap_q,     cap_d;
  logic [1:0]        bufOk_q,   bufOk_d;
  logic [1:0][7:0]   loBuf_q,   loBuf_d;
  logic              irq_q,     irq_d;

  // decode
  logic       addrRd;
  logic       addrWr;
  logic [7:0] aOfs;
  logic       wrLo;
  logic       extSel;
  logic       presTick;
  logic       extTick;
  logic       cntTick;
  logic       reload;
  logic       ovfSet;
  logic [1:0] capEvent;
  logic [1:0] capSet;
  logic       cntLoAccess;
  logic [1:0] capLoAccess;
  logic [7:0] rdByte;

  assign aOfs = haddr[ADDR_W-1:0];

  always_comb begin
    addrRd = hsel & hready & htrans[1] & ~hwrite & (hsize == HSIZE_WORD);
    addrWr = hsel & hready & htrans[1] & hwrite & (hsize == HSIZE_WORD);
    wrLo   = dph_q & dphWr_q & ((dphAddr_q == OFS_CNT_LO) | (dphAddr_q == OFS_ALT_LO));
    reload = wrLo;
    extSel = (ctrl2_q.clockSel == SEL_EXT);
    // counting runs in wait as normal; only halt stops it
    presTick = ((presc_q & prescMask(ctrl2_q.clockSel)) ==
                prescMask(ctrl2_q.clockSel));
    extTick  = edgeHit(pinNow[0], pinPrev[0], ctrl2_q.extEdge);
    cntTick  = ~haltMode & (extSel ? extTick : presTick);
    ovfSet   = cntTick & ~reload & (count_q == COUNT_MAX);
    capEvent[0] = edgeHit(pinNow[1], pinPrev[1], ctrl1_q.capEdgeOne);
    capEvent[1] = edgeHit(pinNow[2], pinPrev[2], ctrl2_q.capEdgeTwo);
    capSet      = capEvent & ~capLock_q;
    cntLoAccess = (addrRd & (aOfs == OFS_CNT_LO)) |
                  (dph_q & dphWr_q & (dphAddr_q == OFS_CNT_LO));
    capLoAccess[0] = (addrRd & (aOfs == OFS_CAP1_LO)) |
                     (dph_q & dphWr_q & (dphAddr_q == OFS_CAP1_LO));
    capLoAccess[1] = (addrRd & (aOfs == OFS_CAP2_LO)) |
                     (dph_q & dphWr_q & (dphAddr_q == OFS_CAP2_LO));
  end

  always_comb begin
    dph_d     = addrRd | addrWr;
    dphWr_d   = addrWr;
    dphAddr_d = (addrRd | addrWr) ? aOfs : dphAddr_q;
    ctrl1_d   = ctrl1_q;
    ctrl2_d   = ctrl2_q;
    presc_d   = (haltMode | extSel) ? presc_q : presc_q + 3'h1;
    count_d   = count_q;
    ovf_d     = ovf_q;
    ovfArm_d  = ovfArm_q;
    capFlag_d = capFlag_q;
    capArm_d  = capArm_q;
    capLock_d = capLock_q;
    cap_d     = cap_q;
    bufOk_d   = bufOk_q;
    loBuf_d   = loBuf_q;
    rdByte    = 8'h00;

    // register writes land in the data phase; capture writes are dropped
    if (dph_q & dphWr_q) begin
      case (dphAddr_q)
        OFS_CTRL1: ctrl1_d = hwdata[2:0];
        OFS_CTRL2: ctrl2_d = hwdata[3:0];
        default:   ;
      endcase
    end

    // reads answer from the address phase so data stand in the data phase
    if (addrRd) begin
      case (aOfs)
        OFS_CTRL1:  rdByte = {5'h00, ctrl1_q};
        OFS_CTRL2:  rdByte = {4'h0, ctrl2_q};
        OFS_STATUS: begin
          rdByte = {1'b0, pinNow, 1'b0, capFlag_q, ovf_q};
          if (ovf_q) ovfArm_d = 1'b1;
          capArm_d = capArm_q | capFlag_q;
        end
        OFS_CNT_HI, OFS_ALT_HI: begin
          rdByte = byteOf(count_q, 1'b1);
          if (!bufOk_q[aOfs == OFS_ALT_HI]) begin
            bufOk_d[aOfs == OFS_ALT_HI] = 1'b1;
            loBuf_d[aOfs == OFS_ALT_HI] = byteOf(count_q, 1'b0);
          end
        end
        OFS_CNT_LO, OFS_ALT_LO: begin
          rdByte = bufOk_q[aOfs == OFS_ALT_LO] ? loBuf_q[aOfs == OFS_ALT_LO]
                                               : byteOf(count_q, 1'b0);
          bufOk_d[aOfs == OFS_ALT_LO] = 1'b0;
        end
        OFS_CAP1_HI: begin
          rdByte       = byteOf(cap_q[0], 1'b1);
          capLock_d[0] = 1'b1;
        end
        OFS_CAP2_HI: begin
          rdByte       = byteOf(cap_q[1], 1'b1);
          capLock_d[1] = 1'b1;
        end
        OFS_CAP1_LO: begin
          rdByte       = byteOf(cap_q[0], 1'b0);
          capLock_d[0] = 1'b0;
        end
        OFS_CAP2_LO: begin
          rdByte       = byteOf(cap_q[1], 1'b0);
          capLock_d[1] = 1'b0;
        end
        default: rdByte = 8'h00;
      endcase
    end
    hrdata_d = {24'h00_0000, rdByte};

    // clears first, hardware sets after so a coincident event survives
    if (cntLoAccess & ovfArm_q) begin
      ovf_d    = 1'b0;
      ovfArm_d = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      if (capLoAccess[i] & capArm_q[i]) begin
        capFlag_d[i] = 1'b0;
        capArm_d[i]  = 1'b0;
      end
      if (capSet[i]) begin
        cap_d[i]     = count_q;
        capFlag_d[i] = 1'b1;
      end
    end

    if (reload) begin
      count_d = COUNT_RESET;
      presc_d = 3'h0;
    end else if (cntTick) begin
      count_d = count_q + 16'h0001;
    end
    if (ovfSet) ovf_d = 1'b1;

    irq_d = ~globalIrqMask & ((ctrl1_q.ovfIrqEn & ovf_q) |
                              (ctrl1_q.capIrqEn & (|capFlag_q)));
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dph_q     <= 1'b0;
      dphWr_q   <= 1'b0;
      dphAddr_q <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
      ctrl1_q   <= CTRL1_RESET;
      ctrl2_q   <= CTRL2_RESET;
      count_q   <= COUNT_RESET;
      presc_q   <= 3'h0;
      ovf_q     <= 1'b0;
      ovfArm_q  <= 1'b0;
      capFlag_q <= 2'h0;
      capArm_q  <= 2'h0;
      capLock_q <= 2'h0;
      cap_q     <= '0;
      bufOk_q   <= 2'h0;
      loBuf_q   <= '0;
      irq_q     <= 1'b0;
    end else begin
      dph_q     <= dph_d;
      dphWr_q   <= dphWr_d;
      dphAddr_q <= dphAddr_d;
      hrdata_q  <= hrdata_d;
      ctrl1_q   <= ctrl1_d;
      ctrl2_q   <= ctrl2_d;
      count_q   <= count_d;
      presc_q   <= presc_d;
      ovf_q     <= ovf_d;
      ovfArm_q  <= ovfArm_d;
      capFlag_q <= capFlag_d;
      capArm_q  <= capArm_d;
      capLock_q <= capLock_d;
      cap_q     <= cap_d;
      bufOk_q   <= bufOk_d;
      loBuf_q   <= loBuf_d;
      irq_q     <= irq_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign timerIrq  = irq_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence sLoWrAddr;
    addrWr && (aOfs == OFS_CNT_LO || aOfs == OFS_ALT_LO);
  endsequence

  sequence sHiRead;
    addrRd && aOfs == OFS_CNT_HI && !bufOk_q[0];
  endsequence

  reload_value_a: assert property (sLoWrAddr ##1 1'b1 |=> count_q == COUNT_RESET)
    else $error("low byte write did not reload count");

  wrap_flag_a: assert property (cntTick && !reload && count_q == COUNT_MAX
      |=> ovf_q && count_q == 16'h0000)
    else $error("wrap did not set overflow flag");

  irq_gate_a: assert property (globalIrqMask |=> !timerIrq)
    else $error("interrupt raised while masked");

  ovf_hold_a: assert property (ovf_q && !(cntLoAccess && ovfArm_q) |=> ovf_q)
    else $error("overflow flag cleared without sequence");

  halt_freeze_a: assert property (haltMode && !reload |=> $stable(count_q))
    else $error("count moved during halt");

  lo_buffer_a: assert property (sHiRead ##1 (!(addrRd && aOfs == OFS_CNT_LO))[*3]
      |-> loBuf_q[0] == $past(count_q[7:0], 3))
    else $error("buffered low byte changed");

  cap_latch_a: assert property (capSet[0]
      |=> cap_q[0] == $past(count_q) && capFlag_q[0])
    else $error("capture did not latch count");

  cap_lock_a: assert property (capLock_q[1] |=> $stable(cap_q[1]))
    else $error("capture updated while locked");

  ext_only_a: assert property (extSel && !extTick && !reload |=> $stable(count_q))
    else $error("count moved without external edge");

  presc_rate_a: assert property (!extSel && !haltMode && !reload
      && ctrl2_q.clockSel == SEL_DIV2 && $stable(ctrl2_q) && !presTick
      |=> count_q == $past(count_q))
    else $error("prescaler ticked early");

endmodule : frt_timer

// ===== tb/frt_pin_model.sv
/*
  Pin-side partner: external clock and both capture pins of the timer.
  Assumes ref_clk from the bench; pins move 7 ns or 3 ns off its edges.
*/
`timescale 1ns/1ns
module frt_pin_model (
  input  wire logic       ref_clk,
  input  wire logic       extRun,
  input  wire logic [3:0] halfCycles,
  input  wire logic [1:0] capLevel,
  output logic            extClockPin,
  output logic            capturePinOne,
  output logic            capturePinTwo,
  output int              rises,
  output int              falls
);
  int phase = 0;

  initial begin
    extClockPin = 1'b0;
    rises = 0;
    falls = 0;
  end

  // stands still between runs; a half period below 2 would break spacing
  always @(posedge ref_clk) begin
    if (extRun) begin
      phase = phase + 1;
      if (phase >= ((halfCycles < 2) ? 2 : halfCycles)) begin
        phase = 0;
        #7 extClockPin = ~extClockPin;
        if (extClockPin) rises++;
        else falls++;
      end
    end
  end

  assign #3 capturePinOne = capLevel[0];
  assign #3 capturePinTwo = capLevel[1];
endmodule : frt_pin_model

// ===== tb/frt_timer_tb.sv
/*
  Self-checking bench of the timer: AHB-Lite master tasks, a cycle-count
  model of the counter, and the pin partner. Assumes zero or more wait states.
*/
`timescale 1ns/1ns
module frt_timer_tb;
  import frt_pkg::*;
  logic ref_clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, r;
  logic [1:0] htrans = 2'h0, capLevel = 2'h0;
  logic globalIrqMask = 1'b1, haltMode = 1'b0, extRun = 1'b0;
  logic [3:0] halfCycles = 4'h5;
  logic hreadyout, hresp, timerIrq, extClockPin, capturePinOne, capturePinTwo;
  logic [15:0] v, w;
  int nErrors = 0, nCompared = 0, cyc = 0, mark, rises, falls, e0, seed = 69;

  always #10 ref_clk = ~ref_clk;
  // model time base: halted cycles do not count
  always @(posedge ref_clk) if (arst_n && !haltMode) cyc <= cyc + 1;

  frt_timer frt_timer_i (.ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .globalIrqMask(globalIrqMask), .haltMode(haltMode),
    .extClockPin(extClockPin), .capturePinOne(capturePinOne),
    .capturePinTwo(capturePinTwo), .timerIrq(timerIrq));
  frt_pin_model frt_pin_model_i (.ref_clk(ref_clk), .extRun(extRun),
    .halfCycles(halfCycles), .capLevel(capLevel), .extClockPin(extClockPin),
    .capturePinOne(capturePinOne), .capturePinTwo(capturePinTwo),
    .rises(rises), .falls(falls));

  task automatic report_and_stop;
    if (nErrors == 0 && nCompared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0000_00, a};
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one tick of slack covers the prescaler phase at the sample edge
  task automatic near(input logic [15:0] got, input int ticks);
    logic [15:0] exp, diff;
    exp = 16'hFFFC + ticks[15:0];
    diff = got - exp;
    nCompared++;
    if (diff !== 16'h0000 && diff !== 16'h0001 && diff !== 16'hFFFF) begin
      nErrors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : near

  task automatic rd16(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
    v[15:8] = r[7:0];
    bus(1'b0, a + 8'h04, 32'h0);
    v[7:0] = r[7:0];
  endtask : rd16

  task automatic reload;
    bus(1'b1, OFS_CNT_LO, 32'h0000_00A5);
    mark = cyc;
  endtask : reload

  initial begin
    repeat (60000) @(posedge ref_clk);
    nErrors++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    bus(1'b0, 8'h40, 32'h0);
    chk(r, 32'h0000_0000);
    chk(hresp, 1'b0);
    bus(1'b1, OFS_CTRL1, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, OFS_CTRL2, (i == 0) ? SEL_DIV2 : (i == 1) ? SEL_DIV4 : SEL_DIV8);
      reload();
      repeat (150 + ($random(seed) & 63)) @(posedge ref_clk);
      haltMode <= 1'b1;
      repeat (40) @(posedge ref_clk);
      haltMode <= 1'b0;
      chk(timerIrq, 1'b0);
      globalIrqMask <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk(timerIrq, 1'b1);
      globalIrqMask <= 1'b1;
      e0 = cyc;
      bus(1'b0, OFS_CNT_HI, 32'h0);
      w[15:8] = r[7:0];
      bus(1'b0, OFS_CNT_HI, 32'h0);
      repeat (20) @(posedge ref_clk);
      bus(1'b0, OFS_CNT_LO, 32'h0);
      w[7:0] = r[7:0];
      near(w, (e0 - mark) / (2 << i));
      bus(1'b0, OFS_ALT_LO, 32'h0);
      near({w[15:8], r[7:0]}, (cyc - mark) / (2 << i));
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(r[0], 1'b1);
      bus(1'b0, OFS_ALT_LO, 32'h0);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(r[0], 1'b1);
      bus(1'b0, OFS_CNT_LO, 32'h0);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(r[0], 1'b0);
    end
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, OFS_CTRL2, {1'b0, i[0], SEL_EXT} | 32'h0);
      halfCycles <= i ? 4'h6 : 4'h2;
      reload();
      e0 = i ? rises : falls;
      extRun <= 1'b1;
      repeat (80) @(posedge ref_clk);
      extRun <= 1'b0;
      repeat (10) @(posedge ref_clk);
      rd16(OFS_ALT_HI);
      near(v, (i ? rises : falls) - e0);
    end
    bus(1'b1, OFS_CTRL1, 32'h0000_0004);
    bus(1'b1, OFS_CTRL2, 32'h0000_0008 | SEL_DIV8);
    for (int i = 0; i < 2; i++) begin
      // synchronisers leave reset high, so a low pin gives a stale flag
      bus(1'b0, OFS_STATUS, 32'h0);
      bus(1'b0, i ? OFS_CAP2_LO : OFS_CAP1_LO, 32'h0);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(r[1+i], 1'b0);
      reload();
      repeat (40) @(posedge ref_clk);
      capLevel[i] <= 1'b1;
      e0 = cyc;
      repeat (10) @(posedge ref_clk);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(r[1+i], 1'b1);
      rd16(i ? OFS_CAP2_HI : OFS_CAP1_HI);
      near(v, (e0 - mark + 3) / 8);
      w = v;
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(r[1+i], 1'b0);
      bus(1'b1, i ? OFS_CAP2_HI : OFS_CAP1_HI, 32'h0000_0000);
      bus(1'b1, i ? OFS_CAP2_LO : OFS_CAP1_LO, 32'h0000_0000);
      rd16(i ? OFS_CAP2_HI : OFS_CAP1_HI);
      chk(v, w);
      bus(1'b0, i ? OFS_CAP2_HI : OFS_CAP1_HI, 32'h0);
      capLevel[i] <= 1'b0;
      repeat (10) @(posedge ref_clk);
      capLevel[i] <= 1'b1;
      repeat (10) @(posedge ref_clk);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(r[1+i], 1'b0);
      bus(1'b0, i ? OFS_CAP2_LO : OFS_CAP1_LO, 32'h0);
    end
    report_and_stop();
  end
endmodule : frt_timer_tb
